// ### hw/pcfg_pkg.sv
/*
 pcfg_pkg: offsets, field positions, fixed values and reset values of the
 configuration space, plus the burst timer state type.
 assumes: byte-addressed space, each register one aligned 32-bit word.
*/
package pcfg_pkg;
	localparam int ADDR_W = 8;
	localparam int SPACE_BYTES = 256;
	localparam int HDR_BYTES = 64;
	localparam logic [7:0] OFS_IDENT = 8'h00;
	localparam logic [7:0] OFS_CMDSTAT = 8'h04;
	localparam logic [7:0] OFS_CLASS = 8'h08;
	localparam logic [7:0] OFS_HDRLAT = 8'h0C;
	localparam logic [7:0] OFS_MEMBASE = 8'h10;
	localparam logic [7:0] OFS_SUBSYS = 8'h2C;
	localparam logic [7:0] OFS_LATINT = 8'h3C;
	localparam int ST_PERR = 31;
	localparam int ST_MABORT = 29;
	localparam int ST_TABORT_RX = 28;
	localparam int ST_TABORT_TX = 27;
	localparam int DEVSEL_HI = 26;
	localparam int DEVSEL_LO = 25;
	localparam logic [1:0] DEVSEL_FAST = 2'h0;
	localparam int CMD_MASTER = 2;
	localparam int CMD_MEM = 1;
	localparam logic [23:0] CLASS_CODE = 24'h04_0000;
	localparam logic [7:0] HDR_TYPE = 8'h00;
	localparam logic [7:0] LAT_RST = 8'h00;
	localparam int LAT_FIXED_BITS = 3;
	localparam int BASE_LSB = 12;
	localparam logic [7:0] MAX_LAT_VAL = 8'h10;
	localparam logic [7:0] MIN_GNT_VAL = 8'h02;
	localparam logic [7:0] INT_PIN_VAL = 8'h01;
	localparam logic [7:0] INT_LINE_RST = 8'h0A;
	localparam int LANE_CMD = 0;
	localparam int LANE_LAT = 1;
	localparam int LANE_INTLINE = 0;
	localparam int LANE_BASE_LO = 1;
	localparam int LANE_BASE_MID = 2;
	localparam int LANE_BASE_HI = 3;
	typedef enum logic [1:0] {
		PCFG_IDLE = 2'h0,
		PCFG_RUN = 2'h1,
		PCFG_COUNT = 2'h3,
		PCFG_STOP = 2'h2
	} pcfg_tmr_t;
endpackage : pcfg_pkg

// ### hw/pcfg_sub_if.sv
/*
 pcfg_sub_if: signals between the register bank and its two helpers,
 the burst limit timer and the subsystem strap latch.
 assumes: all three modules share one clock.
*/
`timescale 1ns/1ps
interface pcfg_sub_if;
	logic [7:0] lat_timer;
	logic burst_active;
	logic gnt;
	logic burst_stop;
	logic [31:0] strap_word;
	logic strap_valid;
	modport owner (output lat_timer, output burst_active, output gnt,
		input burst_stop, input strap_word, input strap_valid);
	modport timer (input lat_timer, input burst_active, input gnt, output burst_stop);
	modport strap (output strap_word, output strap_valid);
endinterface : pcfg_sub_if

// ### hw/pcfg_strap_latch.sv
/*
 pcfg_strap_latch: catches the 32 subsystem identity straps at the first
 edge after the bus reset is released.
 assumes: the board holds the straps steady for some clocks after release.
*/
`timescale 1ns/1ps
module pcfg_strap_latch (
	input wire logic clk,
	input wire logic reset,
	input wire logic [31:0] strap_pins,
	pcfg_sub_if.strap s
);
	import pcfg_pkg::*;

	logic armed_ff;
	logic [31:0] word_ff;
	logic valid_ff;

	// the straps are sampled by the clock after release, never by the reset itself
	always_ff @(posedge clk) begin
		if (reset) begin
			armed_ff <= 1'b1;
			valid_ff <= 1'b0;
			word_ff <= 32'h0000_0000;
		end else if (armed_ff) begin
			armed_ff <= 1'b0;
			valid_ff <= 1'b1;
			word_ff <= strap_pins; // [RULE20]
		end
	end

	assign s.strap_word = word_ff;
	assign s.strap_valid = valid_ff;

	a_strap_capture: assert property (@(posedge clk) disable iff (reset) // [RULE20]
		$past(reset) |-> ##1 (valid_ff && word_ff == $past(strap_pins)))
		else $error("straps not caught after reset release");
endmodule : pcfg_strap_latch

// ### hw/pcfg_burst_timer.sv
/*
 pcfg_burst_timer: once grant is withdrawn during an own burst, counts the
 latency timer down and then asks the bus engine to end the burst.
 assumes: burst_active is high for the whole own burst, gnt is the arbiter grant.
*/
`timescale 1ns/1ps
module pcfg_burst_timer (
	input wire logic clk,
	input wire logic reset,
	pcfg_sub_if.timer t
);
	import pcfg_pkg::*;

	pcfg_tmr_t state_ff;
	pcfg_tmr_t nxt_state;
	logic [7:0] cnt_ff;
	logic stop_ff;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
		PCFG_IDLE: if (t.burst_active) nxt_state = PCFG_RUN;
		PCFG_RUN: begin
			if (!t.burst_active) nxt_state = PCFG_IDLE;
			else if (!t.gnt) nxt_state = (t.lat_timer == LAT_RST) ? PCFG_STOP : PCFG_COUNT;
		end
		PCFG_COUNT: begin
			// a grant that comes back does not cancel the countdown
			if (!t.burst_active) nxt_state = PCFG_IDLE;
			else if (cnt_ff == 8'h01) nxt_state = PCFG_STOP; // [RULE17]
		end
		PCFG_STOP: if (!t.burst_active) nxt_state = PCFG_IDLE;
		default: nxt_state = PCFG_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) state_ff <= PCFG_IDLE;
		else state_ff <= nxt_state;
	end

	always_ff @(posedge clk) begin
		if (reset) cnt_ff <= LAT_RST;
		else if (state_ff == PCFG_RUN) cnt_ff <= t.lat_timer;
		else if (state_ff == PCFG_COUNT) cnt_ff <= cnt_ff - 8'h01;
	end

	always_ff @(posedge clk) begin
		if (reset) stop_ff <= 1'b0;
		else stop_ff <= (nxt_state == PCFG_STOP); // [RULE17]
	end

	assign t.burst_stop = stop_ff;

	a_stop_on_count: assert property (@(posedge clk) disable iff (reset) // [RULE17]
		(state_ff == PCFG_COUNT && cnt_ff == 8'h01 && t.burst_active) |=> stop_ff)
		else $error("burst not ended when latency count ran out");
endmodule : pcfg_burst_timer

// ### hw/pcfg_regs.sv
/*
 pcfg_regs: configuration space of the video bus controller: identity,
 command and read-clear status, class, latency timer, memory window base,
 strapped subsystem identity, interrupt routing. Also produces the master
 permit, the memory window claim and the burst end request.
 assumes: the bus-cycle engine decodes a configuration cycle into a one-cycle
 cfg_req with byte address and byte enables; event inputs are one-cycle pulses;
 everything is synchronous to clk.
*/
// Notes on behaviour
// RULE1 - 256 byte locations, first 64 form header
// RULE2 - undefined locations read back all zeros
// RULE3 - answer configuration cycles only with idsel high
// RULE4 - identity word fixed, writes ignored
// RULE5 - parity error flag sticky, cleared by read
// RULE6 - master abort flag sticky, cleared by read
// RULE7 - target abort received flag, cleared by read
// RULE8 - target abort signalled flag, cleared by read
// RULE9 - device select timing reads as fast
// RULE10 - unsupported command and status bits read zero
// RULE11 - master enable writable, resets zero, gates mastering
// RULE12 - memory enable writable, resets zero, gates claims
// RULE13 - class code fixed at multimedia video
// RULE14 - revision code fixed and read only
// RULE15 - header type and unused bytes read zero
// RULE16 - latency timer writable, low three bits zero
// RULE17 - end burst latency clocks after grant removed
// RULE18 - base address upper bits writable, 4 KB window
// RULE19 - subsystem identity word read only
// RULE20 - straps caught just after reset release
// RULE21 - maximum latency field fixed value
// RULE22 - minimum grant field fixed value
// RULE23 - interrupt pin field shows first interrupt line
// RULE24 - interrupt line scratch byte, resets to ten
// RULE25 - soft hold keeps registers, blocks mastering only
// RULE26 - read returns flag, clears it, new event wins
`timescale 1ns/1ps
module pcfg_regs #(
	parameter logic [15:0] DEVICE_CODE = 16'h0A5C, // value arbitrary
	parameter logic [15:0] VENDOR_CODE = 16'h0F1E, // value arbitrary
	parameter logic [7:0] REVISION_CODE = 8'h01 // value arbitrary
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic cfg_req,
	input wire logic idsel,
	input wire logic cfg_wr,
	input wire logic [pcfg_pkg::ADDR_W-1:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata_ff,
	output logic cfg_ack_ff,
	input wire logic ev_parity_err,
	input wire logic ev_master_abort,
	input wire logic ev_target_abort_rx,
	input wire logic ev_target_abort_tx,
	input wire logic soft_hold_bit,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	output logic mem_claim_ff,
	output logic master_permit_ff,
	input wire logic burst_active,
	input wire logic gnt,
	output logic burst_stop_ff,
	input wire logic [31:0] strap_pins
);
	import pcfg_pkg::*;

	logic perr_ff;
	logic mabort_ff;
	logic tabort_rx_ff;
	logic tabort_tx_ff;
	logic master_en_ff;
	logic mem_en_ff;
	logic [7:0] lat_ff;
	logic [31:BASE_LSB] base_ff;
	logic [7:0] int_line_ff;
	logic [7:0] rd_ofs_ff;
	logic rd_seen_ff;
	logic sel;
	logic do_wr;
	logic do_rd;
	logic [7:0] word_ofs;
	logic stat_rd;

	pcfg_sub_if sub ();

	pcfg_strap_latch u_strap (
		.clk(clk),
		.reset(reset),
		.strap_pins(strap_pins),
		.s(sub.strap)
	);

	pcfg_burst_timer u_timer (
		.clk(clk),
		.reset(reset),
		.t(sub.timer)
	);

	assign sub.lat_timer = lat_ff;
	assign sub.burst_active = burst_active;
	assign sub.gnt = gnt;
	assign burst_stop_ff = sub.burst_stop;

	// a configuration cycle counts only with idsel; the low two address bits
	// pick no register, the byte enables select the lanes instead
	assign sel = cfg_req & idsel; // [RULE3]
	assign do_wr = sel & cfg_wr;
	assign do_rd = sel & ~cfg_wr;
	assign word_ofs = {cfg_addr[ADDR_W-1:2], 2'h0}; // [RULE1]
	assign stat_rd = do_rd & (word_ofs == OFS_CMDSTAT);

	function automatic logic lane_wr(input logic [7:0] ofs, input int lane);
		lane_wr = do_wr && (word_ofs == ofs) && cfg_be[lane];
	endfunction : lane_wr

	// set wins over clear so an event landing on the clearing read is kept
	function automatic logic rc_next(input logic flag, input logic ev);
		rc_next = ev | (flag & ~stat_rd); // [RULE26]
	endfunction : rc_next

	function automatic logic [31:0] cfg_word(input logic [7:0] ofs);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (ofs)
		OFS_IDENT: w = {DEVICE_CODE, VENDOR_CODE}; // [RULE4]
		OFS_CMDSTAT: begin
			// all other status and command bits stay zero
			w[ST_PERR] = perr_ff; // [RULE5]
			w[ST_MABORT] = mabort_ff; // [RULE6]
			w[ST_TABORT_RX] = tabort_rx_ff; // [RULE7]
			w[ST_TABORT_TX] = tabort_tx_ff; // [RULE8]
			w[DEVSEL_HI:DEVSEL_LO] = DEVSEL_FAST; // [RULE9] [RULE10]
			w[CMD_MASTER] = master_en_ff; // [RULE11]
			w[CMD_MEM] = mem_en_ff; // [RULE12]
		end
		OFS_CLASS: w = {CLASS_CODE, REVISION_CODE}; // [RULE13] [RULE14]
		OFS_HDRLAT: w = {8'h00, HDR_TYPE, lat_ff, 8'h00}; // [RULE15] [RULE16]
		OFS_MEMBASE: w = {base_ff, {BASE_LSB{1'b0}}}; // [RULE18]
		OFS_SUBSYS: w = sub.strap_word; // [RULE19]
		OFS_LATINT: w = {MAX_LAT_VAL, MIN_GNT_VAL, // [RULE21] [RULE22]
			INT_PIN_VAL, int_line_ff}; // [RULE23] [RULE24]
		default: w = 32'h0000_0000; // [RULE2]
		endcase
		return w;
	endfunction : cfg_word

	// read path: data and acknowledge one clock after the request
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg_rdata_ff <= 32'h0000_0000;
			cfg_ack_ff <= 1'b0;
		end else begin
			cfg_ack_ff <= sel; // [RULE3]
			if (do_rd) cfg_rdata_ff <= cfg_word(word_ofs); // [RULE1] [RULE2]
		end
	end

	// helper record of the last read offset, used by the checks below
	always_ff @(posedge clk) begin
		if (reset) begin
			rd_ofs_ff <= 8'h00;
			rd_seen_ff <= 1'b0;
		end else begin
			rd_seen_ff <= do_rd;
			if (do_rd) rd_ofs_ff <= word_ofs;
		end
	end

	// sticky error flags; soft hold does not touch them
	always_ff @(posedge clk) begin
		if (reset) begin
			perr_ff <= 1'b0;
			mabort_ff <= 1'b0;
			tabort_rx_ff <= 1'b0;
			tabort_tx_ff <= 1'b0;
		end else begin
			perr_ff <= rc_next(perr_ff, ev_parity_err); // [RULE5] [RULE26]
			mabort_ff <= rc_next(mabort_ff, ev_master_abort); // [RULE6]
			tabort_rx_ff <= rc_next(tabort_rx_ff, ev_target_abort_rx); // [RULE7]
			tabort_tx_ff <= rc_next(tabort_tx_ff, ev_target_abort_tx); // [RULE8]
		end
	end

	// command enables, byte lane 0 of the command word
	always_ff @(posedge clk) begin
		if (reset) begin
			master_en_ff <= 1'b0;
			mem_en_ff <= 1'b0;
		end else if (lane_wr(OFS_CMDSTAT, LANE_CMD)) begin
			master_en_ff <= cfg_wdata[CMD_MASTER]; // [RULE11]
			mem_en_ff <= cfg_wdata[CMD_MEM]; // [RULE12]
		end
	end

	// latency timer keeps its low bits at zero so it counts in eights
	always_ff @(posedge clk) begin
		if (reset) lat_ff <= LAT_RST;
		else if (lane_wr(OFS_HDRLAT, LANE_LAT))
			lat_ff <= {cfg_wdata[15:8+LAT_FIXED_BITS], {LAT_FIXED_BITS{1'b0}}}; // [RULE16]
	end

	// memory window base, one writable nibble in lane 1 and full lanes 2 and 3
	always_ff @(posedge clk) begin
		if (reset) base_ff <= '0;
		else begin
			if (lane_wr(OFS_MEMBASE, LANE_BASE_LO))
				base_ff[15:BASE_LSB] <= cfg_wdata[15:BASE_LSB]; // [RULE18]
			if (lane_wr(OFS_MEMBASE, LANE_BASE_MID)) base_ff[23:16] <= cfg_wdata[23:16];
			if (lane_wr(OFS_MEMBASE, LANE_BASE_HI)) base_ff[31:24] <= cfg_wdata[31:24];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) int_line_ff <= INT_LINE_RST;
		else if (lane_wr(OFS_LATINT, LANE_INTLINE)) int_line_ff <= cfg_wdata[7:0]; // [RULE24]
	end

	// memory claims keep working under soft hold; only mastering stops
	always_ff @(posedge clk) begin
		if (reset) mem_claim_ff <= 1'b0;
		else mem_claim_ff <= mem_req & mem_en_ff // [RULE12] [RULE25]
			& (mem_addr[31:BASE_LSB] == base_ff);
	end

	always_ff @(posedge clk) begin
		if (reset) master_permit_ff <= 1'b0;
		else master_permit_ff <= master_en_ff & ~soft_hold_bit; // [RULE11] [RULE25]
	end

	a_ident_fixed: assert property (@(posedge clk) disable iff (reset) // [RULE4]
		(do_rd && word_ofs == OFS_IDENT) |=>
		(cfg_ack_ff && cfg_rdata_ff == {DEVICE_CODE, VENDOR_CODE}))
		else $error("identity word read wrong");

	a_undef_zero: assert property (@(posedge clk) disable iff (reset) // [RULE2]
		(rd_seen_ff && (rd_ofs_ff >= 8'h14) && (rd_ofs_ff <= 8'h28)) |-> cfg_rdata_ff == 32'h0000_0000)
		else $error("undefined location read non-zero");

	a_undef_tail: assert property (@(posedge clk) disable iff (reset) // [RULE2]
		(rd_seen_ff && (rd_ofs_ff >= 8'h30) && (rd_ofs_ff <= 8'h38)) |-> cfg_rdata_ff == 32'h0000_0000)
		else $error("undefined header tail read non-zero");

	a_high_space_zero: assert property (@(posedge clk) disable iff (reset) // [RULE1]
		(rd_seen_ff && (rd_ofs_ff >= 8'(HDR_BYTES))) |-> cfg_rdata_ff == 32'h0000_0000)
		else $error("location above the header read non-zero");

	a_no_idsel: assert property (@(posedge clk) disable iff (reset) // [RULE3]
		(cfg_req && !idsel) |=> !cfg_ack_ff)
		else $error("answered without idsel");

	a_ack_pulse: assert property (@(posedge clk) disable iff (reset) // [RULE3]
		sel |=> cfg_ack_ff)
		else $error("selected access not acknowledged");

	a_ack_only_sel: assert property (@(posedge clk) disable iff (reset) // [RULE3]
		!sel |=> !cfg_ack_ff)
		else $error("acknowledge without a selected access");

	a_rdata_holds: assert property (@(posedge clk) disable iff (reset) // [RULE1]
		!do_rd |=> $stable(cfg_rdata_ff))
		else $error("read data changed without a read");

	a_perr_sets: assert property (@(posedge clk) disable iff (reset) // [RULE5]
		ev_parity_err |=> perr_ff)
		else $error("parity flag not set");

	a_mabort_sets: assert property (@(posedge clk) disable iff (reset) // [RULE6]
		ev_master_abort |=> mabort_ff)
		else $error("master abort flag not set");

	a_tabort_rx_sets: assert property (@(posedge clk) disable iff (reset) // [RULE7]
		ev_target_abort_rx |=> tabort_rx_ff)
		else $error("received target abort flag not set");

	a_tabort_tx_sets: assert property (@(posedge clk) disable iff (reset) // [RULE8]
		ev_target_abort_tx |=> tabort_tx_ff)
		else $error("signalled target abort flag not set");

	a_rc_clear: assert property (@(posedge clk) disable iff (reset) // [RULE26]
		(stat_rd && perr_ff && !ev_parity_err) |=> (!perr_ff && cfg_rdata_ff[ST_PERR]))
		else $error("read-clear flag not returned then cleared");

	a_rc_all_clear: assert property (@(posedge clk) disable iff (reset) // [RULE26]
		(stat_rd && !(ev_parity_err || ev_master_abort || ev_target_abort_rx || ev_target_abort_tx))
		|=> !(perr_ff || mabort_ff || tabort_rx_ff || tabort_tx_ff))
		else $error("status read left a flag set");

	a_tabort_hold: assert property (@(posedge clk) disable iff (reset) // [RULE8]
		(tabort_tx_ff && !stat_rd) |=> tabort_tx_ff)
		else $error("target abort flag dropped without read");

	a_status_fixed: assert property (@(posedge clk) disable iff (reset) // [RULE9] [RULE10]
		(rd_seen_ff && rd_ofs_ff == OFS_CMDSTAT) |->
		(cfg_rdata_ff[26:23] == 4'h0 && cfg_rdata_ff[9:6] == 4'h0 && !cfg_rdata_ff[0]))
		else $error("hardwired status or command bit non-zero");

	a_cmd_en_wr: assert property (@(posedge clk) disable iff (reset) // [RULE11] [RULE12]
		(do_wr && word_ofs == OFS_CMDSTAT && cfg_be[LANE_CMD]) |=>
		(master_en_ff == $past(cfg_wdata[CMD_MASTER]) && mem_en_ff == $past(cfg_wdata[CMD_MEM])))
		else $error("command enables not written");

	a_class_word: assert property (@(posedge clk) disable iff (reset) // [RULE13] [RULE14]
		(do_rd && word_ofs == OFS_CLASS) |=> cfg_rdata_ff == {CLASS_CODE, REVISION_CODE})
		else $error("class word wrong");

	a_hdr_word: assert property (@(posedge clk) disable iff (reset) // [RULE15]
		(do_rd && word_ofs == OFS_HDRLAT) |=>
		(cfg_rdata_ff[31:16] == {8'h00, HDR_TYPE} && cfg_rdata_ff[7:0] == 8'h00))
		else $error("header type or unused byte non-zero");

	a_lat_low_zero: assert property (@(posedge clk) disable iff (reset) // [RULE16]
		lat_ff[LAT_FIXED_BITS-1:0] == '0)
		else $error("latency timer low bits set");

	a_lat_write: assert property (@(posedge clk) disable iff (reset) // [RULE16]
		(do_wr && word_ofs == OFS_HDRLAT && cfg_be[LANE_LAT]) |=>
		lat_ff[7:LAT_FIXED_BITS] == $past(cfg_wdata[15:8+LAT_FIXED_BITS]))
		else $error("latency timer not written");

	a_base_low_zero: assert property (@(posedge clk) disable iff (reset) // [RULE18]
		(do_rd && word_ofs == OFS_MEMBASE) |=> cfg_rdata_ff[BASE_LSB-1:0] == {BASE_LSB{1'b0}})
		else $error("memory base low bits non-zero");

	a_reset_values: assert property (@(posedge clk) // [RULE11] [RULE12] [RULE16] [RULE24]
		reset |=> (!master_en_ff && !mem_en_ff && lat_ff == LAT_RST && base_ff == '0
		&& int_line_ff == INT_LINE_RST))
		else $error("reset value wrong");

	a_int_line_wr: assert property (@(posedge clk) disable iff (reset) // [RULE24]
		(do_wr && word_ofs == OFS_LATINT && cfg_be[LANE_INTLINE]) |=>
		int_line_ff == $past(cfg_wdata[7:0]))
		else $error("interrupt line not written");

	a_claim_gate: assert property (@(posedge clk) disable iff (reset) // [RULE12]
		(mem_req && !mem_en_ff) |=> !mem_claim_ff)
		else $error("memory claimed while disabled");

	a_claim_window: assert property (@(posedge clk) disable iff (reset) // [RULE18]
		(mem_req && mem_en_ff && mem_addr[31:BASE_LSB] == base_ff) |=> mem_claim_ff)
		else $error("window access not claimed");

	a_hold_master: assert property (@(posedge clk) disable iff (reset) // [RULE25]
		(soft_hold_bit || !master_en_ff) |=> !master_permit_ff)
		else $error("mastering allowed under soft hold or disable");

	a_permit_follow: assert property (@(posedge clk) disable iff (reset) // [RULE11]
		(master_en_ff && !soft_hold_bit) |=> master_permit_ff)
		else $error("mastering not allowed while enabled");

	a_latint_word: assert property (@(posedge clk) disable iff (reset) // [RULE21] [RULE22] [RULE23]
		(do_rd && word_ofs == OFS_LATINT) |=>
		cfg_rdata_ff[31:8] == {MAX_LAT_VAL, MIN_GNT_VAL, INT_PIN_VAL})
		else $error("latency and interrupt pin fields wrong");

	a_subsys_ro: assert property (@(posedge clk) disable iff (reset) // [RULE19]
		(do_rd && word_ofs == OFS_SUBSYS) |=> cfg_rdata_ff == sub.strap_word)
		else $error("subsystem word not the strapped value");
endmodule : pcfg_regs

// ### tb/pcfg_host_model.sv
/*
 pcfg_host_model: host bridge side, issues one configuration cycle per call.
 assumes: inputs change at the falling edge; ack is a one-cycle register pulse.
*/
`timescale 1ns/1ps
module pcfg_host_model (
	input wire logic clk,
	output logic cfg_req,
	output logic idsel,
	output logic cfg_wr,
	output logic [7:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata_ff,
	input wire logic cfg_ack_ff
);
	initial begin
		cfg_req = 1'h0;
		idsel = 1'h0;
		cfg_wr = 1'h0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end
	task automatic access(input logic wr, input logic sel, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd,
		output logic ack);
		@(negedge clk);
		cfg_req = 1'h1;
		idsel = sel;
		cfg_wr = wr;
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = wd;
		// taken at the rising edge in between; the acknowledge stands one
		// cycle only, so it is caught here before the lines are released
		@(negedge clk);
		ack = cfg_ack_ff;
		rd = cfg_rdata_ff;
		// released cfg_wr, cfg_addr, cfg_be and cfg_wdata carry the inverse so a stale value cannot pass; cfg_req and idsel drop low
		cfg_req = 1'h0;
		idsel = 1'h0;
		cfg_wr = ~wr;
		cfg_addr = ~a;
		cfg_be = ~be;
		cfg_wdata = ~wd;
	endtask : access
endmodule : pcfg_host_model

// ### tb/pcfg_regs_tb_top.sv
/*
 pcfg_regs_tb_top: self-checking bench for the configuration register bank.
 assumes: host model drives config cycles; bench drives events, memory and burst.
*/
`timescale 1ns/1ps
module pcfg_regs_tb_top;
	import pcfg_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [3:0] be;
		logic [31:0] wd;
		logic [31:0] exp;
	} pcfg_row_t;
	localparam logic [15:0] DEV = 16'h0B0B; // value arbitrary
	localparam logic [15:0] VEN = 16'h0C1C; // value arbitrary
	localparam logic [7:0] REV = 8'h05; // value arbitrary
	localparam logic [31:0] STRAP = 32'h5A3C_96E1;
	localparam logic [31:0] ONES = 32'hFFFF_FFFF;
	logic clk, reset, cfg_req, idsel, cfg_wr, cfg_ack_ff, soft_hold_bit, mem_req;
	logic mem_claim_ff, master_permit_ff, burst_active, gnt, burst_stop_ff, ack;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be, ev;
	logic [31:0] cfg_wdata, cfg_rdata_ff, mem_addr, strap_pins, rd;
	int miscompares = 0;
	int checks = 0;
	pcfg_row_t rows [$] = '{
		'{1'h0, 8'h00, 4'hF, 32'h0, {DEV, VEN}},
		'{1'h0, 8'h04, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h08, 4'hF, 32'h0, {24'h04_0000, REV}},
		'{1'h0, 8'h0C, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h10, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h2C, 4'hF, 32'h0, STRAP},
		'{1'h0, 8'h3C, 4'hF, 32'h0, 32'h1002_010A},
		'{1'h0, 8'h14, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h28, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h30, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h38, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'h40, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h0, 8'hFC, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h1, 8'h00, 4'hF, ONES, 32'h0}, '{1'h0, 8'h00, 4'hF, 32'h0, {DEV, VEN}},
		'{1'h1, 8'h04, 4'hF, ONES, 32'h0}, '{1'h0, 8'h04, 4'hF, 32'h0, 32'h0000_0006},
		'{1'h1, 8'h0C, 4'hF, ONES, 32'h0}, '{1'h0, 8'h0C, 4'hF, 32'h0, 32'h0000_F800},
		'{1'h1, 8'h10, 4'hF, ONES, 32'h0}, '{1'h0, 8'h10, 4'hF, 32'h0, 32'hFFFF_F000},
		'{1'h1, 8'h2C, 4'hF, ONES, 32'h0}, '{1'h0, 8'h2C, 4'hF, 32'h0, STRAP},
		'{1'h1, 8'h14, 4'hF, ONES, 32'h0}, '{1'h0, 8'h14, 4'hF, 32'h0, 32'h0000_0000},
		'{1'h1, 8'h3C, 4'hF, ONES, 32'h0}, '{1'h0, 8'h3C, 4'hF, 32'h0, 32'h1002_01FF},
		'{1'h1, 8'h0C, 4'h2, 32'h0000_0900, 32'h0},
		'{1'h1, 8'h3C, 4'h2, 32'h0, 32'h0}, '{1'h0, 8'h3C, 4'hF, 32'h0, 32'h1002_01FF},
		'{1'h0, 8'h0C, 4'hF, 32'h0, 32'h0000_0800}
	};
	pcfg_regs #(.DEVICE_CODE(DEV), .VENDOR_CODE(VEN), .REVISION_CODE(REV)) dut (
		.clk(clk), .reset(reset), .cfg_req(cfg_req), .idsel(idsel), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata_ff(cfg_rdata_ff), .cfg_ack_ff(cfg_ack_ff),
		.ev_parity_err(ev[3]), .ev_master_abort(ev[2]), .ev_target_abort_rx(ev[1]),
		.ev_target_abort_tx(ev[0]), .soft_hold_bit(soft_hold_bit), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_claim_ff(mem_claim_ff), .master_permit_ff(master_permit_ff),
		.burst_active(burst_active), .gnt(gnt), .burst_stop_ff(burst_stop_ff),
		.strap_pins(strap_pins)
	);
	pcfg_host_model host (
		.clk(clk), .cfg_req(cfg_req), .idsel(idsel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
		.cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata_ff(cfg_rdata_ff),
		.cfg_ack_ff(cfg_ack_ff)
	);
	always #20 clk = ~clk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic chkb(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask : chkb
	task automatic rw(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		host.access(wr, 1'h1, a, be, wd, rd, ack);
		chkb(ack, 1'h1);
	endtask : rw
	// memory cycle; the claim register answers at the take edge for one cycle
	task automatic claim(input logic [31:0] a, input logic exp);
		@(negedge clk);
		mem_req = 1'h1;
		mem_addr = a;
		@(negedge clk);
		chkb(mem_claim_ff, exp);
		mem_req = 1'h0;
		mem_addr = ~a;
	endtask : claim
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	initial begin
		#160000;
		miscompares++;
		stop_test();
	end
	initial begin
		clk = 1'h0;
		reset = 1'h1;
		ev = 4'h0;
		soft_hold_bit = 1'h0;
		mem_req = 1'h0;
		mem_addr = 32'h0000_0000;
		burst_active = 1'h0;
		gnt = 1'h1;
		strap_pins = STRAP;
		repeat (6) @(negedge clk);
		chk({cfg_rdata_ff[31:4], cfg_ack_ff, mem_claim_ff, master_permit_ff, burst_stop_ff},
			32'h0000_0000);
		reset = 1'h0;
		repeat (4) @(negedge clk);
		// straps are past their hold time, later changes must not show
		strap_pins = ~STRAP;
		foreach (rows[i]) begin
			rw(rows[i].wr, rows[i].a, rows[i].be, rows[i].wd);
			if (!rows[i].wr)
				chk(rd, rows[i].exp);
		end
		host.access(1'h1, 1'h0, 8'h3C, 4'hF, 32'h0, rd, ack);
		chkb(ack, 1'h0);
		rw(1'h0, 8'h3C, 4'hF, 32'h0);
		chk(rd, 32'h1002_01FF);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			ev[i] = 1'h1;
			@(negedge clk);
			ev[i] = 1'h0;
			rw(1'h0, 8'h04, 4'hF, 32'h0);
			chk(rd, 32'h0000_0006 |
				(32'h0000_0001 << ((i == 3) ? 31 : 27 + i)));
			rw(1'h0, 8'h04, 4'h1, 32'h0);
			chk(rd, 32'h0000_0006);
		end
		fork
			rw(1'h0, 8'h04, 4'hF, 32'h0);
			begin
				@(negedge clk);
				ev[3] = 1'h1;
				@(negedge clk);
				ev[3] = 1'h0;
			end
		join
		chk(rd, 32'h0000_0006);
		rw(1'h0, 8'h04, 4'hF, 32'h0);
		chk(rd, 32'h8000_0006);
		chkb(master_permit_ff, 1'h1);
		claim(32'hFFFF_F123, 1'h1);
		claim(32'hFFFF_E123, 1'h0);
		soft_hold_bit = 1'h1;
		@(negedge clk);
		chkb(master_permit_ff, 1'h0);
		rw(1'h0, 8'h0C, 4'hF, 32'h0);
		chk(rd, 32'h0000_0800);
		claim(32'hFFFF_FFFC, 1'h1);
		soft_hold_bit = 1'h0;
		@(negedge clk);
		chkb(master_permit_ff, 1'h1);
		burst_active = 1'h1;
		@(negedge clk);
		gnt = 1'h0;
		repeat (4) @(negedge clk);
		// grant coming back mid-count must not cancel the countdown
		gnt = 1'h1;
		repeat (4) @(negedge clk);
		chkb(burst_stop_ff, 1'h0);
		@(negedge clk);
		chkb(burst_stop_ff, 1'h1);
		gnt = 1'h1;
		@(negedge clk);
		chkb(burst_stop_ff, 1'h1);
		burst_active = 1'h0;
		@(negedge clk);
		chkb(burst_stop_ff, 1'h0);
		rw(1'h1, 8'h04, 4'h1, 32'h0);
		@(negedge clk);
		chkb(master_permit_ff, 1'h0);
		claim(32'hFFFF_F000, 1'h0);
		reset = 1'h1;
		repeat (2) @(negedge clk);
		reset = 1'h0;
		repeat (2) @(negedge clk);
		rw(1'h0, 8'h3C, 4'hF, 32'h0);
		chk(rd, 32'h1002_010A);
		rw(1'h0, 8'h10, 4'hF, 32'h0);
		chk(rd, 32'h0000_0000);
		rw(1'h0, 8'h2C, 4'hF, 32'h0);
		chk(rd, ~STRAP);
		// a cleared latency timer ends the burst as soon as grant is seen low
		burst_active = 1'h1;
		gnt = 1'h0;
		@(negedge clk);
		chkb(burst_stop_ff, 1'h0);
		@(negedge clk);
		chkb(burst_stop_ff, 1'h1);
		burst_active = 1'h0;
		gnt = 1'h1;
		@(negedge clk);
		chkb(burst_stop_ff, 1'h0);
		stop_test();
	end
endmodule : pcfg_regs_tb_top
